/* File: rtl/lsf_pkg.sv */
package lsf_pkg;

    // Clock rate of the flag logic.
    localparam int unsigned CLK_MHZ          = 250;
    // Least PWM high time that releases start-up, in nanoseconds.
    localparam int unsigned PWM_MIN_NS       = 200;
    localparam int unsigned PWM_MIN_CYC      = (PWM_MIN_NS * CLK_MHZ + 999) / 1000;
    // Default blanking delay after each PWM enable, in nanoseconds.
    localparam int unsigned BLANK_NS         = 1000;
    localparam int unsigned BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;
    // Default number of LED strings.
    localparam int unsigned NUM_STRINGS      = 4;
    // Width of the blanking and pulse counters.
    localparam int unsigned CNT_W            = 16;
    // Reset value of a fault output: released, pulled high.
    localparam logic        FLAG_RELEASED    = 1'b1;

    // Start-up sequence states.
    typedef enum logic [1:0]
    {
        ST_LOCKOUT,
        ST_WAIT_PWM,
        ST_RUN
    } lsf_phase_type;

endpackage

/* File: rtl/lsf_blank_if.sv */
// Carries the blanking state from the blanking counter to the flag logic.
interface lsf_blank_if;
    logic pwm_rise;
    logic armed;

    modport ctrl (output pwm_rise, input armed);
    modport blank (input pwm_rise, output armed);
endinterface

/* File: rtl/lsf_blank.sv */
// Blanking timer: after each PWM rise, holds detection off for BLANK_CYC cycles.
module lsf_blank #(
    parameter int unsigned BLANK_CYC = lsf_pkg::BLANK_CYC
) (
    input  wire logic  ref_clk_i,
    input  wire logic  resetn_i,
    input  wire logic  pwm_i,
    lsf_blank_if.blank bif
);

    typedef struct packed
    {
        logic [lsf_pkg::CNT_W-1:0] cnt;
        logic                      armed;
    } lsf_blank_state_type;

    lsf_blank_state_type st_reg;
    lsf_blank_state_type st_next;

    // Refuse a blanking length that the counter cannot hold.
    if (BLANK_CYC < 1 || BLANK_CYC >= (1 << lsf_pkg::CNT_W))
    begin : g_bad_blank
        $error("BLANK_CYC out of range");
    end

    // A rise restarts the count; low PWM disarms at once so the next enable is blanked again.
    always_comb
    begin
        st_next = st_reg;
        if (!pwm_i)
        begin
            st_next.cnt   = '0;
            st_next.armed = 1'b0;
        end
        else if (bif.pwm_rise)
        begin
            st_next.cnt   = lsf_pkg::CNT_W'(BLANK_CYC - 1);
            st_next.armed = 1'b0;
        end
        else if (st_reg.cnt != '0)
        begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        else
        begin
            st_next.armed = 1'b1; // see RQ3, see RQ8
        end
    end

    // State register.
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bif.armed = st_reg.armed;

endmodule

/* File: rtl/lsf_fault_flags.sv */
// Behaviour
// RQ1: Open-string fault output pulls low when any string is open in normal run.
// RQ2: Open detection acts only while PWM is high.
// RQ3: Open flag waits a blanking delay after each PWM enable.
// RQ4: Open detection stays off throughout start-up.
// RQ5: Short fault output pulls low when any sink is shorted to boost output.
// RQ6: A shorted string's sink is disabled at once; others keep running.
// RQ7: Short detection acts only while PWM is high.
// RQ8: Short flag waits a blanking delay after each PWM enable.
// RQ9: Short fault output stays released throughout start-up.
// RQ10: Start-up waits for a first PWM high pulse of at least 200 ns.
// RQ11: Undervoltage or shutdown stops switching and re-enters start-up.
// RQ12: Fault outputs release whenever fault absent, gated, blanked or in start-up.
module lsf_fault_flags #(
    parameter int unsigned NUM_STRINGS = lsf_pkg::NUM_STRINGS,
    parameter int unsigned BLANK_CYC   = lsf_pkg::BLANK_CYC
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   pwm_i,
    input  wire logic                   supply_ok_i,
    input  wire logic                   shutdown_ok_i,
    input  wire logic [NUM_STRINGS-1:0] string_open_i,
    input  wire logic [NUM_STRINGS-1:0] string_short_i,
    output logic                        switch_en_o,
    output logic                        soft_start_o,
    output logic [NUM_STRINGS-1:0]      sink_en_o,
    output logic                        open_string_fault_n_o,
    output logic                        open_string_fault_n_oe_o,
    output logic                        shorted_string_fault_n_o,
    output logic                        shorted_string_fault_n_oe_o
);

    typedef struct packed
    {
        lsf_pkg::lsf_phase_type    phase;
        logic [lsf_pkg::CNT_W-1:0] pulse_cnt;
        logic                      pwm_d;
        logic                      switch_en;
        logic                      soft_start;
        logic [NUM_STRINGS-1:0]    sink_off;
        logic [NUM_STRINGS-1:0]    sink_en;
        logic                      open_drive;
        logic                      short_drive;
    } lsf_state_type;

    lsf_state_type st_reg;
    lsf_state_type st_next;
    lsf_blank_if   bif ();
    logic          power_ok;
    logic          detect_ok;

    // Refuse string counts that the sink vector and the fault OR cannot serve.
    if (NUM_STRINGS < 1 || NUM_STRINGS > 32)
    begin : g_bad_strings
        $error("NUM_STRINGS out of range");
    end

    lsf_blank #(
        .BLANK_CYC (BLANK_CYC)
    ) u_blank (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .pwm_i     (pwm_i),
        .bif       (bif)
    );

    // A PWM rise seen against the registered copy starts each blanking window.
    assign bif.pwm_rise = pwm_i && !st_reg.pwm_d;
    assign power_ok     = supply_ok_i && shutdown_ok_i;
    // Detection needs normal run, PWM high and the blanking window passed.
    assign detect_ok    = (st_reg.phase == lsf_pkg::ST_RUN) && pwm_i && bif.armed; // see RQ2, see RQ7, see RQ4

    // Start-up sequence, sink control and flag drive.
    always_comb
    begin
        st_next       = st_reg;
        st_next.pwm_d = pwm_i;
        case (st_reg.phase)
            lsf_pkg::ST_LOCKOUT:
            begin
                st_next.switch_en  = 1'b0;
                st_next.soft_start = 1'b1;
                st_next.pulse_cnt  = '0;
                if (power_ok)
                begin
                    st_next.phase = lsf_pkg::ST_WAIT_PWM;
                end
            end
            lsf_pkg::ST_WAIT_PWM:
            begin
                // Count consecutive PWM high cycles; a short glitch does not release start-up.
                if (!pwm_i)
                begin
                    st_next.pulse_cnt = '0;
                end
                else if (st_reg.pulse_cnt < lsf_pkg::CNT_W'(lsf_pkg::PWM_MIN_CYC - 1))
                begin
                    st_next.pulse_cnt = st_reg.pulse_cnt + 1'b1;
                end
                else
                begin
                    st_next.phase      = lsf_pkg::ST_RUN; // see RQ10
                    st_next.switch_en  = 1'b1;
                    st_next.soft_start = 1'b0;
                end
            end
            lsf_pkg::ST_RUN:
            begin
                st_next.switch_en  = 1'b1;
                st_next.soft_start = 1'b0;
            end
            default:
            begin
                st_next.phase = lsf_pkg::ST_LOCKOUT;
            end
        endcase

        // Undervoltage or shutdown overrides everything but the flag drives in the same cycle.
        if (!power_ok)
        begin
            st_next.phase      = lsf_pkg::ST_LOCKOUT; // see RQ11
            st_next.switch_en  = 1'b0;
            st_next.soft_start = 1'b1;
            st_next.pulse_cnt  = '0;
        end

        // A shorted sink stays off until start-up is re-entered; this guards against
        // re-enabling into a hard short every PWM period.
        if (detect_ok)
        begin
            st_next.sink_off = st_reg.sink_off | string_short_i; // see RQ6
        end
        if (st_next.phase != lsf_pkg::ST_RUN)
        begin
            st_next.sink_off = '0;
        end

        // Sink enables are registered so the sink gates never see a combinational glitch.
        st_next.sink_en = ~st_next.sink_off & {NUM_STRINGS{st_next.switch_en}}; // see RQ6

        // Flags pull low only while detection is allowed and a fault is present.
        st_next.open_drive  = detect_ok && (|string_open_i); // see RQ1, see RQ12
        st_next.short_drive = detect_ok && (|string_short_i); // see RQ5, see RQ8, see RQ9
    end

    // State register.
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg            <= '0;
            st_reg.phase      <= lsf_pkg::ST_LOCKOUT;
            st_reg.soft_start <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Open-collector pins: the low level is constant, the enable carries the flag.
    assign open_string_fault_n_o       = ~lsf_pkg::FLAG_RELEASED;
    assign shorted_string_fault_n_o    = ~lsf_pkg::FLAG_RELEASED;
    assign open_string_fault_n_oe_o    = st_reg.open_drive;
    assign shorted_string_fault_n_oe_o = st_reg.short_drive;
    assign switch_en_o                 = st_reg.switch_en;
    assign soft_start_o                = st_reg.soft_start;
    assign sink_en_o                   = st_reg.sink_en;

    // Assertions; outputs are registered, so effects are checked one edge or more after their cause; a_wait_holds_off compares phase and outputs at the same edge.
    a_open_needs_run: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ4
        open_string_fault_n_oe_o |-> $past(st_reg.phase) == lsf_pkg::ST_RUN)
        else $error("open flag driven outside run");
    a_short_needs_run: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ9
        shorted_string_fault_n_oe_o |-> $past(st_reg.phase) == lsf_pkg::ST_RUN)
        else $error("short flag driven outside run");
    a_open_pwm_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ2
        !pwm_i |=> !open_string_fault_n_oe_o)
        else $error("open flag driven with pwm low");
    a_short_pwm_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ7
        !pwm_i |=> !shorted_string_fault_n_oe_o)
        else $error("short flag driven with pwm low");
    a_open_blanked: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ3
        bif.pwm_rise |=> !open_string_fault_n_oe_o [*2])
        else $error("open flag inside blanking");
    a_short_blanked: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ8
        bif.pwm_rise |=> !shorted_string_fault_n_oe_o [*2])
        else $error("short flag inside blanking");
    a_blank_disarm: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ3
        bif.pwm_rise |=> !bif.armed)
        else $error("blanking not restarted on pwm rise");
    a_open_flag_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ1
        detect_ok && (|string_open_i) |=> open_string_fault_n_oe_o)
        else $error("open fault not flagged");
    a_short_flag_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ5
        detect_ok && (|string_short_i) |=> shorted_string_fault_n_oe_o)
        else $error("short fault not flagged");
    a_short_sink_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ6
        detect_ok && string_short_i[0] && power_ok |=> !sink_en_o[0])
        else $error("shorted sink left on");
    a_sink_latched: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ6
        (detect_ok && string_short_i[NUM_STRINGS-1] && power_ok) ##1 power_ok |=> !sink_en_o[NUM_STRINGS-1])
        else $error("shorted sink re-enabled in run");
    a_lockout_stop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ11
        !power_ok |=> !switch_en_o && soft_start_o)
        else $error("switching after lockout");
    a_release_pulse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ10
        $rose(switch_en_o) |-> $past(pwm_i, 1) && $past(pwm_i, 2))
        else $error("start released without pwm pulse");
    a_wait_holds_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ10
        st_reg.phase != lsf_pkg::ST_RUN |-> !switch_en_o && soft_start_o)
        else $error("switching before start-up release");
    a_flags_released: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see RQ12
        !detect_ok |=> !open_string_fault_n_oe_o && !shorted_string_fault_n_oe_o)
        else $error("flag driven while detection off");

    c_start_release: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(switch_en_o));
    c_open_flag: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(open_string_fault_n_oe_o));
    c_short_flag: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(shorted_string_fault_n_oe_o));
    c_relockout: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $fell(switch_en_o));
    c_sink_cut: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        shorted_string_fault_n_oe_o && !sink_en_o[0] && switch_en_o);

endmodule

/* File: tb/lsf_strings_model.sv */
// Stands in for the four strings and the host, whose flag lines have pull-ups.
module lsf_strings_model
(
    input  wire logic       open_oe_i,
    input  wire logic       short_oe_i,
    input  wire logic       open_data_i,
    input  wire logic       short_data_i,
    input  wire logic [3:0] open_cmd_i,
    input  wire logic [3:0] short_cmd_i,
    output logic [3:0]      string_open_o,
    output logic [3:0]      string_short_o,
    output logic            open_pin_o,
    output logic            short_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // A short to the boost node stays until the bench lifts it, even with the sink off.
    assign string_open_o  = open_cmd_i;
    assign string_short_o = short_cmd_i;

    // A driven flag line shows the pin data; a released one floats up to the pull-up level.
    assign open_pin_o  = open_oe_i ? open_data_i : 1'b1;
    assign short_pin_o = short_oe_i ? short_data_i : 1'b1;
endmodule

/* File: tb/lsf_fault_flags_tb_top.sv */
module lsf_fault_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned BLANK = 4;
    logic        ref_clk;
    logic        resetn;
    logic        pwm;
    logic        supply_ok;
    logic        shutdown_ok;
    logic [3:0]  open_cmd;
    logic [3:0]  short_cmd;
    logic [3:0]  string_open;
    logic [3:0]  string_short;
    logic [3:0]  sink_en;
    logic [3:0]  mask;
    logic        switch_en;
    logic        soft_start;
    logic        open_oe;
    logic        short_oe;
    logic        open_pin;
    logic        open_data;
    logic        short_data;
    logic        short_pin;
    logic [31:0] lfsr;
    int          mismatches;
    int          checks;
    int          cycles;

    lsf_fault_flags #(.NUM_STRINGS(4), .BLANK_CYC(BLANK)) dut (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .pwm_i(pwm), .supply_ok_i(supply_ok),
        .shutdown_ok_i(shutdown_ok), .string_open_i(string_open), .string_short_i(string_short),
        .switch_en_o(switch_en), .soft_start_o(soft_start), .sink_en_o(sink_en),
        .open_string_fault_n_o(open_data), .open_string_fault_n_oe_o(open_oe),
        .shorted_string_fault_n_o(short_data), .shorted_string_fault_n_oe_o(short_oe));

    lsf_strings_model model (
        .open_oe_i(open_oe), .short_oe_i(short_oe), .open_cmd_i(open_cmd), .short_cmd_i(short_cmd),
        .open_data_i(open_data), .short_data_i(short_data),
        .string_open_o(string_open), .string_short_o(string_short),
        .open_pin_o(open_pin), .short_pin_o(short_pin));

    // The clock toggles every half period of 2 ns.
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Galois shift step; a fixed start keeps every run the same.
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return v[31] ? ({v[30:0], 1'b0} ^ 32'h04c1_1db7) : {v[30:0], 1'b0};
    endfunction

    // A flag line sits low only while its fault is live and detection is allowed.
    function automatic logic exp_pin(input logic [3:0] f, input logic live);
        return (live && (|f)) ? 1'b0 : 1'b1;
    endfunction

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Inputs change at the falling edge, so results of the last rising edge are settled here.
    task automatic tick();
        @(negedge ref_clk);
    endtask

    // A hung run is cut short well past the few hundred cycles the sequence needs.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            finish_test();
        end
    end

    initial
    begin
        {resetn, pwm, open_cmd, short_cmd, mask} = '0;
        {supply_ok, shutdown_ok} = 2'b11;
        lfsr = 32'hde90;
        repeat (16) tick();
        resetn = 1'b1;
        // Faults during start-up, with a PWM pulse two cycles too short to release it, as its first cycle falls in lockout.
        {open_cmd, short_cmd, pwm} = {4'hf, 4'hf, 1'b1};
        repeat (49)
        begin
            tick();
            chk("open_pin", 4'h1, {3'h0, open_pin});
            chk("short_pin", 4'h1, {3'h0, short_pin});
        end
        pwm = 1'b0;
        tick();
        chk("switch_en", 4'h0, {3'h0, switch_en});
        {open_cmd, short_cmd, pwm} = {8'h00, 1'b1};
        // Release needs the full minimum pulse: still held one edge before it, running at it.
        repeat (lsf_pkg::PWM_MIN_CYC - 1) tick();
        chk("switch_en", 4'h0, {3'h0, switch_en});
        tick();
        chk("switch_en", 4'h1, {3'h0, switch_en});
        // Random open strings with PWM steady high; the flag follows the OR of strings.
        repeat (200)
        begin
            lfsr = lfsr_step(lfsr);
            open_cmd = lfsr[4] ? lfsr[3:0] : 4'h0;
            tick();
            chk("open_pin", {3'h0, exp_pin(open_cmd, 1'b1)}, {3'h0, open_pin});
        end
        // PWM low hides faults; a new PWM rise blanks them for BLANK cycles plus the arming edge.
        {open_cmd, short_cmd, pwm} = {4'h5, 4'h1, 1'b0};
        repeat (8)
        begin
            tick();
            chk("open_pin", 4'h1, {3'h0, open_pin});
            chk("short_pin", 4'h1, {3'h0, short_pin});
        end
        pwm = 1'b1;
        repeat (BLANK + 1)
        begin
            tick();
            chk("open_pin", 4'h1, {3'h0, open_pin});
            chk("short_pin", 4'h1, {3'h0, short_pin});
        end
        tick();
        chk("open_pin", 4'h0, {3'h0, open_pin});
        chk("short_pin", 4'h0, {3'h0, short_pin});
        mask = 4'h1;
        {open_cmd, short_cmd} = 8'h00;
        tick();
        chk("short_pin", 4'h1, {3'h0, short_pin});
        // One-cycle shorts on each remaining string; every sink shorted so far stays off.
        for (int k = 1; k < 4; k++)
        begin
            short_cmd = 4'h1 << k;
            mask = mask | short_cmd;
            tick();
            chk("short_pin", 4'h0, {3'h0, short_pin});
            chk("sink_en", ~mask, sink_en);
            short_cmd = 4'h0;
            tick();
            chk("short_pin", 4'h1, {3'h0, short_pin});
        end
        // Supply loss and shutdown each stop switching and restart from the top.
        for (int m = 0; m < 2; m++)
        begin
            {supply_ok, shutdown_ok} = (m == 0) ? 2'b01 : 2'b10;
            tick();
            chk("switch_en", 4'h0, {3'h0, switch_en});
            chk("soft_start", 4'h1, {3'h0, soft_start});
            {supply_ok, shutdown_ok} = 2'b11;
            repeat (60) tick();
            chk("sink_en", 4'hf, sink_en);
        end
        finish_test();
    end
endmodule
